/* hw/cpu_update_timing.sv */
/*
 * frame-synchronous parameter update controller with standard and quick
 * change timing, encapsulated begin/end updates and list updates.
 * assumes host writes arrive on mclk as single-cycle strobes.
 */
// Function
// R1: standard mode keeps frames back to back
// R2: standard shutter change lands two frames later
// R3: newest pending value wins, older ones dropped
// R4: quick mode aborts exposure, restarts with new; code restarts with the old live value, new one lands at next frame start
// R5: quick mode shutter change lands next frame
// R6: quick mode drops frame valid on abort
// R7: encapsulated writes apply together on clear
// R8: standard mode keeps old set while flag set
// R9: quick mode halts while flag is set
// R10: quick mode never sends partial image
// R11: ten second timeout ends encapsulated update
// R12: each begin write restarts the timeout
// R13: flag lives in update timing register
// R14: host orders begin, writes, end
// R15: list accepts up to 64 entries
// R16: standard list keeps old set until copied
// R17: quick list finishes transfer, then re-exposes
// R18: mode bit selects standard or quick timing
// R19: entries are address then value, in order
module cpu_update_timing #(
    parameter longint unsigned TIMEOUT_CYC = cpu_pkg::UPD_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register write port
    input wire logic wr_en,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    // register read port
    input wire logic [31:0] rd_addr,
    output logic [31:0] rd_data,
    // parameter list block write
    input wire logic list_valid,
    input wire logic list_last,
    input wire cpu_pkg::cpu_entry_t list_entry,
    // frame outputs
    output logic frame_valid_out,
    output logic integrating,
    output logic [31:0] active_shutter,
    output logic update_in_progress_flag
);
    logic [31:0] ctrl_reg;
    logic quick_change_mode;
    logic [31:0] pend_reg;
    logic pend_valid_reg;
    logic [31:0] stage1;
    logic [31:0] live;
    logic stage1_load;
    logic live_load;
    logic [1:0] delay_reg;
    logic [63:0] tmo_reg;
    logic tmo_hit;
    logic [6:0] list_cnt_reg;
    logic list_busy_reg;
    logic abort_now;
    logic [15:0] cnt_reg;
    cpu_pkg::cpu_frame_state_t st_reg;
    logic frame_start;
    logic wr_ctrl;
    logic wr_shutter;

    assign quick_change_mode = ctrl_reg[cpu_pkg::MODE_BIT]; // R18
    assign wr_ctrl = wr_en && wr_addr == cpu_pkg::UPD_TIMING_ADDR;
    assign wr_shutter = wr_en && wr_addr == cpu_pkg::SHUTTER_ADDR;
    assign tmo_hit = ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]
        && tmo_reg >= TIMEOUT_CYC - 64'd1; // R11

    // control register, flag held in a field of it
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= cpu_pkg::UPD_TIMING_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= wr_data; // R13
        end else if (tmo_hit) begin
            ctrl_reg[cpu_pkg::IN_PROGRESS_BIT] <= 1'b0; // R11
        end
    end

    // timeout counter, restarted by every begin write
    always_ff @(posedge mclk) begin
        if (srst) begin
            tmo_reg <= 64'd0;
        end else if (wr_ctrl && wr_data[cpu_pkg::IN_PROGRESS_BIT]) begin
            tmo_reg <= 64'd0; // R12
        end else if (ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]) begin
            tmo_reg <= tmo_reg + 64'd1;
        end
    end

    // list intake: up to 64 address/value entries, applied in order
    always_ff @(posedge mclk) begin
        if (srst) begin
            list_cnt_reg <= 7'd0;
            list_busy_reg <= 1'b0;
        end else if (list_valid) begin
            list_busy_reg <= !list_last; // R19
            if (list_last) begin
                list_cnt_reg <= 7'd0;
            end else if (list_cnt_reg != 7'(cpu_pkg::LIST_MAX)) begin
                list_cnt_reg <= list_cnt_reg + 7'd1; // R15
            end
        end else if (!list_busy_reg) begin
            list_cnt_reg <= 7'd0;
        end
    end

    // pending value: newest write overwrites older ones
    always_ff @(posedge mclk) begin
        if (srst) begin
            pend_reg <= {16'h0000, cpu_pkg::EXPOSE_DEFAULT};
            pend_valid_reg <= 1'b0;
        end else if (wr_shutter) begin
            pend_reg <= wr_data; // R3
            pend_valid_reg <= 1'b1;
        end else if (list_valid && list_entry.addr == cpu_pkg::SHUTTER_ADDR
            && list_cnt_reg < 7'(cpu_pkg::LIST_MAX)) begin
            pend_reg <= list_entry.data; // R19
            pend_valid_reg <= 1'b1;
        end else if (stage1_load) begin
            pend_valid_reg <= 1'b0;
        end
    end

    // release of pending set: held back during update or list
    assign stage1_load = pend_valid_reg && !wr_shutter
        && !ctrl_reg[cpu_pkg::IN_PROGRESS_BIT] // R7 R8
        && !list_busy_reg && !list_valid // R16
        && (quick_change_mode ? 1'b1 : frame_start);

    // abort in quick mode on shutter, list or control write during exposure
    assign abort_now = quick_change_mode && st_reg == cpu_pkg::CPU_EXPOSE
        && (wr_shutter || list_valid || wr_ctrl); // R4 R17

    // delay line to frame logic
    always_ff @(posedge mclk) begin
        if (srst) begin
            delay_reg <= 2'd0;
        end else if (stage1_load) begin
            delay_reg <= quick_change_mode
                ? 2'(cpu_pkg::QCM_DELAY_FRAMES)
                : 2'(cpu_pkg::STD_DELAY_FRAMES); // R2 R5
        end else if (frame_start && delay_reg != 2'd0) begin
            delay_reg <= delay_reg - 2'd1;
        end
    end

    assign live_load = frame_start && delay_reg == 2'd1;

    cpu_param_stage u_stage1 (
        .mclk(mclk),
        .srst(srst),
        .load(stage1_load),
        .din(pend_reg),
        .dout(stage1)
    );

    cpu_param_stage u_live (
        .mclk(mclk),
        .srst(srst),
        .load(live_load),
        .din(stage1),
        .dout(live)
    );

    // frame sequencer: expose then read out, no gap in standard mode
    assign frame_start = st_reg == cpu_pkg::CPU_READOUT
        && cnt_reg == cpu_pkg::READOUT_CYC - 16'd1; // R1
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg <= cpu_pkg::CPU_EXPOSE;
            cnt_reg <= 16'd0;
        end else begin
            case (st_reg)
                cpu_pkg::CPU_EXPOSE: begin
                    if (quick_change_mode
                        && ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]) begin
                        st_reg <= cpu_pkg::CPU_HALT; // R9
                        cnt_reg <= 16'd0;
                    end else if (abort_now) begin
                        cnt_reg <= 16'd0; // R4
                    end else if (cnt_reg >= live[15:0]) begin
                        st_reg <= cpu_pkg::CPU_READOUT;
                        cnt_reg <= 16'd0;
                    end else begin
                        cnt_reg <= cnt_reg + 16'd1;
                    end
                end
                cpu_pkg::CPU_READOUT: begin
                    // a running transfer always completes
                    if (frame_start) begin
                        st_reg <= cpu_pkg::CPU_EXPOSE; // R10
                        cnt_reg <= 16'd0;
                    end else begin
                        cnt_reg <= cnt_reg + 16'd1;
                    end
                end
                cpu_pkg::CPU_HALT: begin
                    if (!ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]
                        && !list_busy_reg) begin
                        st_reg <= cpu_pkg::CPU_EXPOSE; // R9 R17
                    end
                    cnt_reg <= 16'd0;
                end
                default: begin
                    st_reg <= cpu_pkg::CPU_EXPOSE;
                    cnt_reg <= 16'd0;
                end
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_valid_out <= 1'b0;
            integrating <= 1'b0;
            active_shutter <= {16'h0000, cpu_pkg::EXPOSE_DEFAULT};
            update_in_progress_flag <= 1'b0;
        end else begin
            frame_valid_out <= st_reg == cpu_pkg::CPU_READOUT; // R6
            integrating <= st_reg == cpu_pkg::CPU_EXPOSE;
            active_shutter <= live;
            update_in_progress_flag <= ctrl_reg[cpu_pkg::IN_PROGRESS_BIT];
        end
    end

    // register read
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_addr == cpu_pkg::UPD_TIMING_ADDR) begin
            rd_data <= ctrl_reg;
        end else if (rd_addr == cpu_pkg::SHUTTER_ADDR) begin
            rd_data <= live;
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    // assertions
    property p_flag_hold;
        @(posedge mclk) disable iff (srst)
        (ctrl_reg[cpu_pkg::IN_PROGRESS_BIT] && !wr_shutter && !wr_ctrl
            && !tmo_hit) |=> !stage1_load;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("load in update"); // R8

    property p_halt;
        @(posedge mclk) disable iff (srst)
        (quick_change_mode && ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]
            && st_reg == cpu_pkg::CPU_EXPOSE) |=> st_reg == cpu_pkg::CPU_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt"); // R9

    property p_readout_whole;
        @(posedge mclk) disable iff (srst)
        (st_reg == cpu_pkg::CPU_READOUT && !frame_start)
            |=> st_reg == cpu_pkg::CPU_READOUT;
    endproperty
    a_readout_whole: assert property (p_readout_whole) // R10
        else $error("partial image");

    property p_abort;
        @(posedge mclk) disable iff (srst)
        (abort_now && !ctrl_reg[cpu_pkg::IN_PROGRESS_BIT])
            |=> cnt_reg == 16'd0;
    endproperty
    a_abort: assert property (p_abort) else $error("no restart"); // R4

    property p_begin_restart;
        @(posedge mclk) disable iff (srst)
        (wr_ctrl && wr_data[cpu_pkg::IN_PROGRESS_BIT]) |=> tmo_reg == 64'd0;
    endproperty
    a_begin_restart: assert property (p_begin_restart) // R12
        else $error("timeout not restarted");

    property p_timeout;
        @(posedge mclk) disable iff (srst)
        (tmo_hit && !wr_ctrl) |=> !ctrl_reg[cpu_pkg::IN_PROGRESS_BIT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout kept"); // R11

    property p_delay;
        @(posedge mclk) disable iff (srst)
        stage1_load
            |=> delay_reg == ($past(quick_change_mode) ? 2'd1 : 2'd2);
    endproperty
    a_delay: assert property (p_delay) else $error("bad delay"); // R2

    property p_latest;
        @(posedge mclk) disable iff (srst)
        wr_shutter |=> pend_reg == $past(wr_data) && pend_valid_reg;
    endproperty
    a_latest: assert property (p_latest) else $error("not newest"); // R3

    // entries past the list limit leave the pending value alone
    property p_list_cap;
        @(posedge mclk) disable iff (srst)
        (list_valid && !wr_shutter
            && list_cnt_reg == 7'(cpu_pkg::LIST_MAX)) |=> $stable(pend_reg);
    endproperty
    a_list_cap: assert property (p_list_cap) // R15
        else $error("entry past limit applied");

    // an open list keeps the previous set in force
    property p_list_hold;
        @(posedge mclk) disable iff (srst)
        (list_busy_reg || list_valid) |-> !stage1_load;
    endproperty
    a_list_hold: assert property (p_list_hold) // R16
        else $error("early list load");

    // halt ends into a fresh exposure once flag and list are clear
    sequence s_halt_released;
        st_reg == cpu_pkg::CPU_HALT && !ctrl_reg[cpu_pkg::IN_PROGRESS_BIT]
            && !list_busy_reg;
    endsequence

    sequence s_fresh_expose;
        st_reg == cpu_pkg::CPU_EXPOSE && cnt_reg == 16'd0;
    endsequence

    property p_resume;
        @(posedge mclk) disable iff (srst)
        s_halt_released |=> s_fresh_expose;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume"); // R9

    // frame stage takes the staged value at the counted frame start
    property p_live_take;
        @(posedge mclk) disable iff (srst)
        live_load |=> live == $past(stage1);
    endproperty
    a_live_take: assert property (p_live_take) // R5
        else $error("live not taken");

    // frame valid only follows a readout state
    property p_fv_readout;
        @(posedge mclk) disable iff (srst)
        (st_reg != cpu_pkg::CPU_READOUT) |=> !frame_valid_out;
    endproperty
    a_fv_readout: assert property (p_fv_readout) // R6
        else $error("frame valid outside readout");

    // readout ends straight into the next exposure, no idle gap
    property p_no_gap;
        @(posedge mclk) disable iff (srst)
        frame_start |=> s_fresh_expose;
    endproperty
    a_no_gap: assert property (p_no_gap) // R1
        else $error("gap after readout");
endmodule

/* hw/cpu_pkg.sv */
/*
 * package for the camera parameter update timing block: register address,
 * field positions, timing constants, state enums and carrier structs.
 * assumes a 125 mhz frame logic clock and a 32-bit register write port.
 */
package cpu_pkg;
    // clock and timeout
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned UPD_TIMEOUT_S = 10;
    localparam longint unsigned UPD_TIMEOUT_CYC =
        (longint'(UPD_TIMEOUT_S) * 64'd1000000000) / CLK_PERIOD_NS;

    // register map
    localparam logic [31:0] UPD_TIMING_ADDR = 32'hF100_0570;
    localparam logic [31:0] LIST_BASE_ADDR = 32'hF100_0600;
    localparam int unsigned IN_PROGRESS_BIT = 25;
    localparam int unsigned MODE_BIT = 0;
    localparam logic [31:0] UPD_TIMING_RESET = 32'h0000_0000;

    // frame timing
    localparam int unsigned LIST_MAX = 64;
    localparam int unsigned STD_DELAY_FRAMES = 2;
    localparam int unsigned QCM_DELAY_FRAMES = 1;
    localparam logic [15:0] EXPOSE_DEFAULT = 16'h0100;
    localparam logic [15:0] READOUT_CYC = 16'h0400;
    localparam logic [31:0] SHUTTER_ADDR = 32'hF0F0_081C;

    typedef enum logic [1:0] {
        CPU_EXPOSE, CPU_READOUT, CPU_HALT
    } cpu_frame_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } cpu_entry_t;
endpackage

/* hw/cpu_param_stage.sv */
/*
 * one parameter stage: holds a value and loads it on a strobe.
 * assumes the loading strobe is synchronous to mclk.
 */
module cpu_param_stage (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // load path
    input wire logic load,
    input wire logic [31:0] din,
    // stored value
    output logic [31:0] dout
);
    // reset value is the default shutter
    always_ff @(posedge mclk) begin
        if (srst) begin
            dout <= {16'h0000, cpu_pkg::EXPOSE_DEFAULT};
        end else if (load) begin
            dout <= din;
        end
    end
endmodule

/* tb/cpu_host_model.sv */
/*
 * host model: register writes and list block writes toward the camera.
 * assumes mclk from the bench and calls only after reset release.
 */
module cpu_host_model (
    // clock
    input wire logic mclk,
    // register write port
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    // list port
    output logic list_valid,
    output logic list_last,
    output cpu_pkg::cpu_entry_t list_entry
);
    // idle values at time zero
    initial begin
        wr_en = 1'b0;
        wr_addr = 32'h0000_0000;
        wr_data = 32'h0000_0000;
        list_valid = 1'b0;
        list_last = 1'b0;
        list_entry = '0;
    end

    // one-cycle write, then bus shows inverted stale values
    task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask

    // begin/end flag writes around parameter writes
    task automatic set_flag(input logic on, input logic quick);
        write_reg(cpu_pkg::UPD_TIMING_ADDR,
            {6'h00, on, 24'h00_0000, quick});
    endtask

    // list in one burst, at most the first 64 entries, address then value, in order
    task automatic send_list(input cpu_pkg::cpu_entry_t q[$]);
        for (int i = 0; i < q.size() && i < cpu_pkg::LIST_MAX; i++) begin
            @(posedge mclk);
            list_valid <= 1'b1;
            list_last <= (i == q.size() - 1);
            list_entry <= q[i];
        end
        @(posedge mclk);
        list_valid <= 1'b0;
        list_last <= 1'b0;
        list_entry <= ~list_entry;
    endtask
endmodule

/* tb/cpu_update_timing_test.sv */
/*
 * self-checking bench for the update timing controller.
 * assumes the design holds its own assertions; timeout shortened to 2000.
 */
module cpu_update_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SH = cpu_pkg::SHUTTER_ADDR;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic wr_en, list_valid, list_last, fv, integ, flag;
    logic stale = 1'b0;
    logic [31:0] wr_addr, wr_data, rd_addr, rd_data, shutter;
    cpu_pkg::cpu_entry_t list_entry;
    cpu_pkg::cpu_entry_t lst[$];
    int error_cnt = 0;
    int cmp_count = 0;
    bit ok;

    // 125 mhz clock
    always #4 mclk = ~mclk;

    cpu_host_model host_u (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .list_valid(list_valid), .list_last(list_last),
        .list_entry(list_entry));

    cpu_update_timing #(.TIMEOUT_CYC(2000)) dut_u (.mclk(mclk), .srst(srst),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .list_valid(list_valid),
        .list_last(list_last), .list_entry(list_entry),
        .frame_valid_out(fv), .integrating(integ),
        .active_shutter(shutter), .update_in_progress_flag(flag));

    // dropped pending value must never become active
    always @(posedge mclk) begin
        if (shutter === 32'h0000_0080) stale <= 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd_addr <= a;
        repeat (3) @(posedge mclk);
        d = rd_data;
    endtask

    // bounded waits; running out counts as a mismatch and ends the run
    task automatic wait_sh(input logic [31:0] v, input int bound);
        ok = 0;
        for (int i = 0; i < bound && !ok; i++) begin
            @(posedge mclk);
            ok = (shutter === v);
        end
        check(shutter, v);
        if (!ok) give_verdict();
    endtask

    task automatic wait_bit(input bit sel_flag, input logic v, input int b);
        ok = 0;
        for (int i = 0; i < b && !ok; i++) begin
            @(posedge mclk);
            ok = sel_flag ? (flag === v) : (integ === v);
        end
        check({31'h0, ok}, 32'h0000_0001);
        if (!ok) give_verdict();
    endtask

    initial begin
        logic [31:0] d;
        rd_addr = 32'h0000_0000;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        // reset values and unmapped read
        read_reg(cpu_pkg::UPD_TIMING_ADDR, d);
        check(d, cpu_pkg::UPD_TIMING_RESET);
        check(shutter, 32'h0000_0100);
        read_reg(32'hF100_0574, d);
        check(d, 32'h0000_0000);
        $display("test reset done");
        // encapsulated update, standard mode
        host_u.set_flag(1'b1, 1'b0);
        wait_bit(1, 1'b1, 4);
        host_u.write_reg(SH, 32'h0000_0040);
        // still inside the timeout, so the flag holds the old set
        repeat (1800) @(posedge mclk);
        check(shutter, 32'h0000_0100);
        check({31'h0, flag}, 32'h0000_0001);
        host_u.set_flag(1'b0, 1'b0);
        wait_sh(32'h0000_0040, 4000);
        $display("test encapsulated done");
        // newest pending value wins
        host_u.write_reg(SH, 32'h0000_0080);
        host_u.write_reg(SH, 32'h0000_0060);
        wait_sh(32'h0000_0060, 4000);
        repeat (3000) @(posedge mclk);
        check({31'h0, stale}, 32'h0000_0000);
        $display("test newest done");
        // begin again restarts the timeout, then timeout applies
        host_u.set_flag(1'b1, 1'b0);
        host_u.write_reg(SH, 32'h0000_0030);
        repeat (1500) @(posedge mclk);
        host_u.set_flag(1'b1, 1'b0);
        repeat (1500) @(posedge mclk);
        check({31'h0, flag}, 32'h0000_0001);
        wait_bit(1, 1'b0, 700);
        wait_sh(32'h0000_0030, 4000);
        $display("test timeout done");
        // quick mode: abort exposure on shutter write
        host_u.write_reg(cpu_pkg::UPD_TIMING_ADDR, 32'h0000_0001);
        read_reg(cpu_pkg::UPD_TIMING_ADDR, d);
        check(d, 32'h0000_0001);
        wait_bit(0, 1'b0, 1400);
        wait_bit(0, 1'b1, 1100);
        host_u.write_reg(SH, 32'h0000_0090);
        // past where the unaborted exposure ends, still integrating
        repeat (48) @(posedge mclk);
        check({31'h0, fv}, 32'h0000_0000);
        check({31'h0, integ}, 32'h0000_0001);
        wait_sh(32'h0000_0090, 1400);
        // quick mode encapsulated: halt until flag clears
        host_u.set_flag(1'b1, 1'b1);
        wait_bit(0, 1'b0, 1400);
        repeat (300) @(posedge mclk);
        check({31'h0, integ}, 32'h0000_0000);
        host_u.set_flag(1'b0, 1'b1);
        wait_bit(0, 1'b1, 10);
        $display("test quick done");
        // list update back in standard mode, last shutter wins
        host_u.write_reg(cpu_pkg::UPD_TIMING_ADDR, 32'h0000_0000);
        lst.push_back('{addr: SH, data: 32'h0000_0050});
        lst.push_back('{addr: 32'hF0F0_0820, data: 32'h8000_00AC});
        lst.push_back('{addr: SH, data: 32'h0000_0020});
        host_u.send_list(lst);
        wait_sh(32'h0000_0020, 4000);
        $display("test list done");
        give_verdict();
    end
endmodule
